// File: scm_defines.svh
`ifndef SCM_DEFINES_SVH
`define SCM_DEFINES_SVH

// ****************************************
// Bus map
// ****************************************
`define SCM_AXI_AW       8
`define SCM_SMC_WIDX     6'h00
`define SCM_RESP_OKAY    2'b00
`define SCM_RESP_SLVERR  2'b10

// ****************************************
// Mode control field positions
// ****************************************
`define SCM_CKS_MSB      7
`define SCM_CKS_LSB      5
`define SCM_FAST_WAKE_ENABLE_BIT    4
`define SCM_LSRDY_BIT    3
`define SCM_HSRDY_BIT    2
`define SCM_IDLE_ENABLE_BIT_BIT    1
`define SCM_HIGH_CLOCK_SELECT_BIT    0

// ****************************************
// Reset values
// ****************************************
`define SCM_CKS_RST      3'h0
`define SCM_FAST_WAKE_ENABLE_RST    1'b0
`define SCM_IDLE_ENABLE_BIT_RST    1'b1
`define SCM_HIGH_CLOCK_SELECT_RST    1'b1

// ****************************************
// Stabilisation counts, in oscillator cycles
// ****************************************
`define SCM_HS_XTAL_STAB 11'h400
`define SCM_HS_RC_STAB   11'h010
`define SCM_LS_XTAL_STAB 11'h400
`define SCM_LS_IRC_STAB  11'h002

`endif

// File: scm_pkg.sv
// ****************************************
// Shared types
// ****************************************
package scm_pkg;

   // High-speed oscillator kind (strap)
   typedef enum logic [1:0] {
      SCM_HS_XTAL,
      SCM_HS_EXT_RC,
      SCM_HS_INT_RC
   } scm_hs_kind_e;

   // Operating mode / wake sequencing states
   typedef enum logic [2:0] {
      SCM_RUN,
      SCM_IDLE_STOP,
      SCM_IDLE_RUN,
      SCM_DEEP_SLEEP,
      SCM_SLEEP_SUB,
      SCM_WAKE,
      SCM_FAST_SYNC,
      SCM_FAST_RUN
   } scm_mode_e;

endpackage : scm_pkg

// File: scm_ready_timer.sv
`timescale 1ns/1ns
// ****************************************
// Oscillator stabilisation timer
// ****************************************
module scm_ready_timer #(
   parameter int CW = 11
) (
   input  wire logic          clk_sys, // System clock
   input  wire logic          rst_n,   // Sync reset, active low
   input  wire logic          run,     // Oscillator enabled
   input  wire logic          tick,    // One oscillator cycle
   input  wire logic [CW-1:0] limit,   // Cycles to stable
   output logic               ready    // Oscillator stable
);

   logic [CW-1:0] count;               // Cycles seen so far

   // Count oscillator cycles; stopping the oscillator clears all
   always_ff @(posedge clk_sys) begin
      if (!rst_n || !run) begin
         count <= '0;
         ready <= 1'b0;
      end else if (tick && !ready) begin
         count <= count + 1'b1;
         if (count + 1'b1 == limit) begin
            ready <= 1'b1;
         end
      end
   end

endmodule : scm_ready_timer

// File: scm_axil_slave.sv
`timescale 1ns/1ns
`include "scm_defines.svh"
// ****************************************
// AXI4-Lite slave, one 8-bit register
// ****************************************
module scm_axil_slave (
   input  wire logic                   clk_sys, // System clock
   input  wire logic                   rst_n,   // Sync reset, low
   input  wire logic [`SCM_AXI_AW-1:0] awaddr,  // Write address
   input  wire logic                   awvalid, // Write addr valid
   output logic                        awready, // Write addr ready
   input  wire logic [31:0]            wdata,   // Write data
   input  wire logic [3:0]             wstrb,   // Byte enables
   input  wire logic                   wvalid,  // Write data valid
   output logic                        wready,  // Write data ready
   output logic [1:0]                  bresp,   // Write response
   output logic                        bvalid,  // Response valid
   input  wire logic                   bready,  // Response ready
   input  wire logic [`SCM_AXI_AW-1:0] araddr,  // Read address
   input  wire logic                   arvalid, // Read addr valid
   output logic                        arready, // Read addr ready
   output logic [31:0]                 rdata,   // Read data
   output logic [1:0]                  rresp,   // Read response
   output logic                        rvalid,  // Read data valid
   input  wire logic                   rready,  // Read data ready
   output logic                        reg_wr,  // Register write
   output logic [7:0]                  reg_wdata, // Write byte
   input  wire logic [7:0]             reg_rdata  // Register value
);

   logic                   aw_got;     // Address held
   logic                   w_got;      // Data held
   logic [`SCM_AXI_AW-1:0] aw_addr;    // Held address
   logic                   w_lane0;    // Byte 0 enabled
   logic                   aw_hit;     // Write decode
   logic                   ar_hit;     // Read decode

   assign aw_hit    = (aw_addr[`SCM_AXI_AW-1:2] == `SCM_SMC_WIDX);
   assign ar_hit    = (araddr[`SCM_AXI_AW-1:2] == `SCM_SMC_WIDX);
   assign reg_wr    = aw_got && w_got && !bvalid && aw_hit && w_lane0;

   // Write channels taken in either order, answer after both
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         awready   <= 1'b0;
         wready    <= 1'b0;
         aw_got    <= 1'b0;
         w_got     <= 1'b0;
         aw_addr   <= '0;
         w_lane0   <= 1'b0;
         reg_wdata <= 8'h00;
         bvalid    <= 1'b0;
         bresp     <= `SCM_RESP_OKAY;
      end else begin
         // Address channel
         if (awvalid && awready) begin
            awready <= 1'b0;
            aw_got  <= 1'b1;
            aw_addr <= awaddr;
         end else if (!aw_got && !bvalid) begin
            awready <= 1'b1;
         end
         // Data channel
         if (wvalid && wready) begin
            wready    <= 1'b0;
            w_got     <= 1'b1;
            w_lane0   <= wstrb[0];
            reg_wdata <= wdata[7:0];
         end else if (!w_got && !bvalid) begin
            wready <= 1'b1;
         end
         // Response
         if (aw_got && w_got && !bvalid) begin
            aw_got <= 1'b0;
            w_got  <= 1'b0;
            bvalid <= 1'b1;
            bresp  <= aw_hit ? `SCM_RESP_OKAY : `SCM_RESP_SLVERR;
         end else if (bvalid && bready) begin
            bvalid <= 1'b0;
         end
      end
   end

   // Read answers on the same edge that takes the address
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         arready <= 1'b0;
         rvalid  <= 1'b0;
         rdata   <= 32'h0000_0000;
         rresp   <= `SCM_RESP_OKAY;
      end else if (arvalid && arready) begin
         arready <= 1'b0;
         rvalid  <= 1'b1;
         rdata   <= ar_hit ? {24'h00_0000, reg_rdata} : 32'h0000_0000;
         rresp   <= ar_hit ? `SCM_RESP_OKAY : `SCM_RESP_SLVERR;
      end else if (rvalid && rready) begin
         rvalid  <= 1'b0;
         arready <= 1'b1;
      end else if (!rvalid) begin
         arready <= 1'b1;
      end
   end

endmodule : scm_axil_slave

// File: scm_ctrl.sv
`timescale 1ns/1ns
`include "scm_defines.svh"
// Summary of operation
// - Ready flag low at power-on, high once stable
// - Software reads high-speed ready as the live flag, clear while stopped
// - Ready low when stopped; HS 1024 or 16 cycles, LS 1024 or 2
// - Halt enters idle if enabled, else sleep
// - Idle keeps or stops clock per keep bit
// - Normal/slow chosen by select bit and divider
// - Low clock selected stops high-speed oscillator
// - Slow switch waits for low-speed ready
// - Fast wake runs on sub clock meanwhile
// - Fast wake only from sub-sleep or idle-stop
// - Crystal fast wake: sub clock until ready
// - RC oscillators ignore fast wake enable
// - Watchdog off deep sleep has no fast wake
// - Divider field decodes low or fH/64..fH/2
// - Sleep is deep unless watchdog or detector on
module scm_ctrl (
   input  wire logic                   clk_sys,   // 10 MHz clock
   input  wire logic                   rst_n,     // Sync reset, low
   input  wire logic [`SCM_AXI_AW-1:0] s_axi_awaddr,  // Write addr
   input  wire logic                   s_axi_awvalid, // Addr valid
   output logic                        s_axi_awready, // Addr ready
   input  wire logic [31:0]            s_axi_wdata,   // Write data
   input  wire logic [3:0]             s_axi_wstrb,   // Byte enables
   input  wire logic                   s_axi_wvalid,  // Data valid
   output logic                        s_axi_wready,  // Data ready
   output logic [1:0]                  s_axi_bresp,   // Write resp
   output logic                        s_axi_bvalid,  // Resp valid
   input  wire logic                   s_axi_bready,  // Resp ready
   input  wire logic [`SCM_AXI_AW-1:0] s_axi_araddr,  // Read addr
   input  wire logic                   s_axi_arvalid, // Addr valid
   output logic                        s_axi_arready, // Addr ready
   output logic [31:0]                 s_axi_rdata,   // Read data
   output logic [1:0]                  s_axi_rresp,   // Read resp
   output logic                        s_axi_rvalid,  // Data valid
   input  wire logic                   s_axi_rready,  // Data ready
   input  wire scm_pkg::scm_hs_kind_e  hs_osc_kind,   // HS osc type
   input  wire logic                   ls_osc_is_xtal, // LS crystal
   input  wire logic                   hs_osc_tick,   // HS cycle
   input  wire logic                   ls_osc_tick,   // Sub cycle
   input  wire logic                   halt_req,      // Halt pulse
   input  wire logic                   wake_req,      // Wake pulse
   input  wire logic                   idle_sysclk_keep, // Keep clk
   input  wire logic                   wdt_enable,    // Watchdog on
   input  wire logic                   lvd_enable,    // Detector on
   output logic                        hs_osc_en,     // HS osc run
   output logic                        ls_osc_en,     // LS osc run
   output logic [3:0]                  sysclk_code,   // Active src
   output logic                        sysclk_on_sub, // Sub clock
   output logic                        cpu_run,       // CPU clocked
   output logic                        sysclk_run,    // Sysclk on
   output scm_pkg::scm_mode_e          mode_state     // Mode
);

   // ****************************************
   // Declarations
   // ****************************************
   logic [2:0]         clock_divider_select; // Divider field
   logic               fast_wake_enable;     // Fast wake bit
   logic               idle_enable_bit;      // Idle on halt
   logic               high_clock_select;    // Full fH select
   logic               hs_ready_flag;        // HS stable
   logic               ls_ready_flag;        // LS stable
   logic               reg_wr;               // Register write
   logic [7:0]         reg_wdata;            // Written byte
   logic [7:0]         reg_rdata;            // Read-back byte
   logic [3:0]         req_src;              // Requested source
   logic               req_hs;               // Request is fH
   logic               act_hs;               // Active is fH
   logic               src_ready;            // Active osc stable
   logic               fast_ok;              // Fast wake allowed
   logic [10:0]        hs_limit;             // HS stable count
   logic [10:0]        ls_limit;             // LS stable count
   scm_pkg::scm_mode_e next_state;           // Next mode
   logic               next_hs_en;           // Next HS enable
   logic               next_ls_en;           // Next LS enable

   // Source is high speed unless low select and 000/001
   function automatic logic is_hs(input logic [3:0] src);
      is_hs = src[3] | src[2] | src[1];
   endfunction : is_hs

   // ****************************************
   // Register bus
   // ****************************************
   scm_axil_slave u_bus (
      .clk_sys   (clk_sys),
      .rst_n     (rst_n),
      .awaddr    (s_axi_awaddr),
      .awvalid   (s_axi_awvalid),
      .awready   (s_axi_awready),
      .wdata     (s_axi_wdata),
      .wstrb     (s_axi_wstrb),
      .wvalid    (s_axi_wvalid),
      .wready    (s_axi_wready),
      .bresp     (s_axi_bresp),
      .bvalid    (s_axi_bvalid),
      .bready    (s_axi_bready),
      .araddr    (s_axi_araddr),
      .arvalid   (s_axi_arvalid),
      .arready   (s_axi_arready),
      .rdata     (s_axi_rdata),
      .rresp     (s_axi_rresp),
      .rvalid    (s_axi_rvalid),
      .rready    (s_axi_rready),
      .reg_wr    (reg_wr),
      .reg_wdata (reg_wdata),
      .reg_rdata (reg_rdata)
   );

   // Writable mode control fields
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         clock_divider_select <= `SCM_CKS_RST;
         fast_wake_enable     <= `SCM_FAST_WAKE_ENABLE_RST;
         idle_enable_bit      <= `SCM_IDLE_ENABLE_BIT_RST;
         high_clock_select    <= `SCM_HIGH_CLOCK_SELECT_RST;
      end else if (reg_wr) begin
         clock_divider_select <= reg_wdata[`SCM_CKS_MSB:`SCM_CKS_LSB];
         fast_wake_enable     <= reg_wdata[`SCM_FAST_WAKE_ENABLE_BIT];
         idle_enable_bit      <= reg_wdata[`SCM_IDLE_ENABLE_BIT_BIT];
         high_clock_select    <= reg_wdata[`SCM_HIGH_CLOCK_SELECT_BIT];
      end
   end

   // Read-back; ready flags are live hardware state
   always_comb begin
      reg_rdata                              = 8'h00;
      reg_rdata[`SCM_CKS_MSB:`SCM_CKS_LSB]   = clock_divider_select;
      reg_rdata[`SCM_FAST_WAKE_ENABLE_BIT]              = fast_wake_enable;
      reg_rdata[`SCM_LSRDY_BIT]              = ls_ready_flag;
      reg_rdata[`SCM_HSRDY_BIT]              = hs_ready_flag;
      reg_rdata[`SCM_IDLE_ENABLE_BIT_BIT]              = idle_enable_bit;
      reg_rdata[`SCM_HIGH_CLOCK_SELECT_BIT]              = high_clock_select;
   end

   // ****************************************
   // Oscillator ready timers
   // ****************************************
   assign hs_limit = (hs_osc_kind == scm_pkg::SCM_HS_XTAL) ?
                     `SCM_HS_XTAL_STAB : `SCM_HS_RC_STAB;
   assign ls_limit = ls_osc_is_xtal ?
                     `SCM_LS_XTAL_STAB : `SCM_LS_IRC_STAB;

   // Flag cleared while stopped, set after the stable count
   scm_ready_timer #(.CW(11)) u_hs_timer (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .run     (hs_osc_en),
      .tick    (hs_osc_tick),
      .limit   (hs_limit),
      .ready   (hs_ready_flag)
   );

   scm_ready_timer #(.CW(11)) u_ls_timer (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .run     (ls_osc_en),
      .tick    (ls_osc_tick),
      .limit   (ls_limit),
      .ready   (ls_ready_flag)
   );

   // ****************************************
   // Clock source selection
   // ****************************************
   assign req_src   = {high_clock_select, clock_divider_select};
   assign req_hs    = is_hs(req_src);
   assign act_hs    = is_hs(sysclk_code);
   assign src_ready = act_hs ? hs_ready_flag : ls_ready_flag;

   // Take the new source only once its oscillator is stable
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         sysclk_code <= {`SCM_HIGH_CLOCK_SELECT_RST, `SCM_CKS_RST};
      end else if (mode_state == scm_pkg::SCM_RUN &&
                   req_src != sysclk_code) begin
         if (req_hs ? hs_ready_flag : ls_ready_flag) begin
            sysclk_code <= req_src;
         end
      end
   end

   // ****************************************
   // Mode sequencing
   // ****************************************
   assign fast_ok = fast_wake_enable && act_hs && ls_osc_en &&
                    hs_osc_kind == scm_pkg::SCM_HS_XTAL;

   // Halt, sleep, idle and wake transitions
   always_comb begin
      next_state = mode_state;
      unique case (mode_state)
         scm_pkg::SCM_RUN: begin
            if (halt_req && idle_enable_bit) begin
               next_state = idle_sysclk_keep ? scm_pkg::SCM_IDLE_RUN :
                            scm_pkg::SCM_IDLE_STOP;
            end else if (halt_req) begin
               next_state = (wdt_enable || lvd_enable) ?
                            scm_pkg::SCM_SLEEP_SUB :
                            scm_pkg::SCM_DEEP_SLEEP;
            end
         end
         scm_pkg::SCM_IDLE_RUN, scm_pkg::SCM_DEEP_SLEEP: begin
            if (wake_req) begin
               next_state = scm_pkg::SCM_WAKE;
            end
         end
         scm_pkg::SCM_IDLE_STOP, scm_pkg::SCM_SLEEP_SUB: begin
            if (wake_req) begin
               next_state = fast_ok ? scm_pkg::SCM_FAST_SYNC :
                            scm_pkg::SCM_WAKE;
            end
         end
         scm_pkg::SCM_WAKE: begin
            if (src_ready) begin
               next_state = scm_pkg::SCM_RUN;
            end
         end
         scm_pkg::SCM_FAST_SYNC: begin
            if (ls_osc_tick) begin
               next_state = scm_pkg::SCM_FAST_RUN;
            end
         end
         scm_pkg::SCM_FAST_RUN: begin
            if (hs_ready_flag) begin
               next_state = scm_pkg::SCM_RUN;
            end
         end
      endcase
   end

   // Oscillator enables per mode
   always_comb begin
      unique case (next_state)
         scm_pkg::SCM_RUN:       next_hs_en = act_hs || req_hs;
         scm_pkg::SCM_IDLE_RUN:  next_hs_en = act_hs;
         scm_pkg::SCM_WAKE, scm_pkg::SCM_FAST_SYNC,
         scm_pkg::SCM_FAST_RUN:  next_hs_en = act_hs;
         scm_pkg::SCM_IDLE_STOP, scm_pkg::SCM_DEEP_SLEEP,
         scm_pkg::SCM_SLEEP_SUB: next_hs_en = 1'b0;
      endcase
      next_ls_en = next_state != scm_pkg::SCM_DEEP_SLEEP &&
                   (wdt_enable || lvd_enable || !act_hs || !req_hs ||
                    next_state == scm_pkg::SCM_IDLE_STOP ||
                    next_state == scm_pkg::SCM_FAST_SYNC ||
                    next_state == scm_pkg::SCM_FAST_RUN);
   end

   // State and registered mode outputs; power-on waits in wake
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         mode_state    <= scm_pkg::SCM_WAKE;
         hs_osc_en     <= 1'b0;
         ls_osc_en     <= 1'b0;
         cpu_run       <= 1'b0;
         sysclk_run    <= 1'b0;
         sysclk_on_sub <= 1'b0;
      end else begin
         mode_state    <= next_state;
         hs_osc_en     <= next_hs_en;
         ls_osc_en     <= next_ls_en;
         cpu_run       <= next_state == scm_pkg::SCM_RUN ||
                          next_state == scm_pkg::SCM_FAST_RUN;
         sysclk_run    <= next_state == scm_pkg::SCM_RUN ||
                          next_state == scm_pkg::SCM_IDLE_RUN ||
                          next_state == scm_pkg::SCM_FAST_RUN;
         sysclk_on_sub <= next_state == scm_pkg::SCM_FAST_RUN;
      end
   end

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   sequence fast_wake_s;
      fast_ok && wake_req &&
      (mode_state == scm_pkg::SCM_SLEEP_SUB ||
       mode_state == scm_pkg::SCM_IDLE_STOP);
   endsequence

   sequence fast_run_s;
      mode_state == scm_pkg::SCM_FAST_SYNC ##[1:1000]
      mode_state == scm_pkg::SCM_FAST_RUN && sysclk_on_sub;
   endsequence

   poweron_ready_a: assert property (
      $rose(rst_n) |-> !hs_ready_flag && !cpu_run)
      else $error("ready flag or cpu active right after reset");

   hs_stop_a: assert property (
      !hs_osc_en |=> !hs_ready_flag)
      else $error("hs ready flag high while oscillator stopped");

   halt_idle_a: assert property (
      mode_state == scm_pkg::SCM_RUN && halt_req && idle_enable_bit
      |=> mode_state inside {scm_pkg::SCM_IDLE_RUN,
                             scm_pkg::SCM_IDLE_STOP})
      else $error("halt with idle enable did not enter idle");

   idle_clock_a: assert property (
      mode_state == scm_pkg::SCM_IDLE_RUN |-> sysclk_run && !cpu_run)
      else $error("idle with kept clock has wrong clock gating");

   slow_wait_a: assert property (
      $fell(act_hs) |-> $past(ls_ready_flag))
      else $error("switched to low clock before it was stable");

   slow_hs_off_a: assert property (
      mode_state == scm_pkg::SCM_RUN && !act_hs && !req_hs
      ##1 mode_state == scm_pkg::SCM_RUN |-> !hs_osc_en)
      else $error("hs oscillator left running on low clock");

   fast_wake_a: assert property (
      fast_wake_s |=> fast_run_s)
      else $error("fast wake did not run on the sub clock");

   fast_end_a: assert property (
      mode_state == scm_pkg::SCM_FAST_RUN && hs_ready_flag
      |=> mode_state == scm_pkg::SCM_RUN && !sysclk_on_sub)
      else $error("fast wake did not hand over to the crystal");

   deep_nofast_a: assert property (
      mode_state == scm_pkg::SCM_DEEP_SLEEP && wake_req && act_hs
      |=> mode_state == scm_pkg::SCM_WAKE && !ls_osc_en)
      else $error("deep sleep wake used the sub clock");

   halt_sleep_a: assert property (
      mode_state == scm_pkg::SCM_RUN && halt_req && !idle_enable_bit &&
      !wdt_enable && !lvd_enable
      |=> mode_state == scm_pkg::SCM_DEEP_SLEEP)
      else $error("halt did not enter deep sleep");

endmodule : scm_ctrl

// File: scm_ctrl_tb.sv
`timescale 1ns/1ns
`include "scm_defines.svh"
module scm_ctrl_tb;
   logic clk_sys = 1'h0;
   logic rst_n = 1'h0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'h0, sysclk_code;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, ls_osc_is_xtal = 1'h0;
   logic hs_osc_tick = 1'h1, ls_osc_tick = 1'h0;
   logic halt_req = 1'h0, wake_req = 1'h0, idle_sysclk_keep = 1'h0;
   logic wdt_enable = 1'h1, lvd_enable = 1'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, hs_osc_en, ls_osc_en, sysclk_on_sub;
   logic cpu_run, sysclk_run;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   scm_pkg::scm_hs_kind_e hs_osc_kind = scm_pkg::SCM_HS_XTAL;
   scm_pkg::scm_mode_e mode_state;
   int error_cnt = 0, n_tests = 0, cyc = 0;
   int seed = 32'h7c20;
   logic [33:0] exp_q[$]; // Expected {rresp, rdata}
   logic [1:0] exp_b[$]; // Expected bresp

   scm_ctrl scm_ctrl_inst (.*);

   always #50 clk_sys = ~clk_sys;

   // Sub clock tick every fourth cycle, and the hang guard
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      ls_osc_tick <= (cyc % 4 == 0);
      if (cyc == 40000) begin
         error_cnt++;
         summarize();
      end
   end

   task automatic chk(string n, logic [33:0] e, logic [33:0] s);
      n_tests++;
      if (s !== e) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", n, e, s);
      end
   endtask : chk

   // Read results are compared against the oldest note
   always @(posedge clk_sys)
      if (s_axi_rvalid === 1'h1 && s_axi_rready === 1'h1)
         chk("rdata", exp_q.pop_front(), {s_axi_rresp, s_axi_rdata});

   // Write responses are compared against the oldest note
   always @(posedge clk_sys)
      if (s_axi_bvalid === 1'h1 && s_axi_bready === 1'h1)
         chk("bresp", exp_b.pop_front(), s_axi_bresp);

   task automatic wr(logic [7:0] a, logic [7:0] d, logic [1:0] er);
      logic [31:0] r;
      r = $random(seed);
      exp_b.push_back(er);
      @(posedge clk_sys);
      s_axi_awaddr <= a;
      s_axi_wdata <= {r[31:8], d};
      s_axi_wstrb <= {r[3:1], 1'h1};
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      do begin
         @(posedge clk_sys);
         if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
         if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
      end while (s_axi_bvalid !== 1'h1);
      s_axi_bready <= 1'h0;
   endtask : wr

   task automatic rd(logic [7:0] a, logic [7:0] v, logic [1:0] er);
      exp_q.push_back({er, 24'h0, v});
      @(posedge clk_sys);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do begin
         @(posedge clk_sys);
         if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
      end while (s_axi_rvalid !== 1'h1);
      s_axi_rready <= 1'h0;
   endtask : rd

   task automatic wm(scm_pkg::scm_mode_e m);
      for (int i = 0; i < 3000 && mode_state !== m; i++) @(posedge clk_sys);
      #1 chk("mode_state", m, mode_state);
   endtask : wm

   task automatic wc(logic [3:0] c);
      for (int i = 0; i < 3000 && sysclk_code !== c; i++) @(posedge clk_sys);
      #1 chk("sysclk_code", c, sysclk_code);
   endtask : wc

   // One-cycle halt (h high) or wake (h low) pulse
   task automatic pul(logic h);
      @(posedge clk_sys);
      halt_req <= h;
      wake_req <= ~h;
      @(posedge clk_sys);
      halt_req <= 1'h0;
      wake_req <= 1'h0;
      #1;
   endtask : pul

   task automatic summarize();
      $display("checks %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : summarize

   initial begin
      repeat (12) @(posedge clk_sys);
      rst_n <= 1'h1;
      wm(scm_pkg::SCM_RUN);
      chk("cpu_run", 1'h1, cpu_run);
      rd(8'h04, 8'h00, 2'h2);
      wr(8'h08, 8'hff, 2'h2);
      rd(8'h00, 8'h0f, 2'h0);
      $display("test reset done");
      wr(8'h00, 8'h20, 2'h0);
      wc(4'h1);
      repeat (2) @(posedge clk_sys);
      chk("hs_osc_en", 1'h0, hs_osc_en);
      for (int k = 2; k < 8; k++) begin
         wr(8'h00, {k[2:0], 5'h00}, 2'h0);
         wc({1'h0, k[2:0]});
      end
      wr(8'h00, 8'h03, 2'h0);
      wc(4'h8);
      $display("test clock switch done");
      @(posedge clk_sys) idle_sysclk_keep <= 1'h1;
      pul(1'h1);
      wm(scm_pkg::SCM_IDLE_RUN);
      chk("sysclk_run", 1'h1, sysclk_run);
      chk("cpu_run", 1'h0, cpu_run);
      pul(1'h0);
      wm(scm_pkg::SCM_RUN);
      @(posedge clk_sys) idle_sysclk_keep <= 1'h0;
      pul(1'h1);
      wm(scm_pkg::SCM_IDLE_STOP);
      chk("sysclk_run", 1'h0, sysclk_run);
      rd(8'h00, 8'h0b, 2'h0);
      pul(1'h0);
      wm(scm_pkg::SCM_RUN);
      rd(8'h00, 8'h0f, 2'h0);
      $display("test idle done");
      wr(8'h00, 8'h11, 2'h0);
      wdt_enable <= 1'h0;
      pul(1'h1);
      wm(scm_pkg::SCM_DEEP_SLEEP);
      chk("ls_osc_en", 1'h0, ls_osc_en);
      rd(8'h00, 8'h11, 2'h0);
      pul(1'h0);
      chk("mode_state", scm_pkg::SCM_WAKE, mode_state);
      wm(scm_pkg::SCM_RUN);
      @(posedge clk_sys) lvd_enable <= 1'h1;
      repeat (20) @(posedge clk_sys);
      rd(8'h00, 8'h1d, 2'h0);
      pul(1'h1);
      wm(scm_pkg::SCM_SLEEP_SUB);
      pul(1'h0);
      wm(scm_pkg::SCM_FAST_RUN);
      chk("sysclk_on_sub", 1'h1, sysclk_on_sub);
      chk("cpu_run", 1'h1, cpu_run);
      wm(scm_pkg::SCM_RUN);
      chk("sysclk_on_sub", 1'h0, sysclk_on_sub);
      $display("test fast wake done");
      @(posedge clk_sys) hs_osc_kind <= scm_pkg::SCM_HS_EXT_RC;
      pul(1'h1);
      wm(scm_pkg::SCM_SLEEP_SUB);
      pul(1'h0);
      chk("mode_state", scm_pkg::SCM_WAKE, mode_state);
      wm(scm_pkg::SCM_RUN);
      $display("test rc wake done");
      @(posedge clk_sys) lvd_enable <= 1'h0;
      ls_osc_is_xtal <= 1'h1;
      hs_osc_kind <= scm_pkg::SCM_HS_INT_RC;
      pul(1'h1);
      wm(scm_pkg::SCM_DEEP_SLEEP);
      pul(1'h0);
      wm(scm_pkg::SCM_RUN);
      @(posedge clk_sys) lvd_enable <= 1'h1;
      repeat (20) @(posedge clk_sys);
      rd(8'h00, 8'h15, 2'h0);
      repeat (4200) @(posedge clk_sys);
      rd(8'h00, 8'h1d, 2'h0);
      $display("test ls crystal done");
      summarize();
   end
endmodule : scm_ctrl_tb
